// ==== dsf_decoder.sv ====
// Seek and set-features command decoder behind an APB task file
`timescale 1ns/1ps
module dsf_decoder
	import dsf_pkg::*;
(
	input wire logic pclk, // 100 MHz clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic realloc_full, // Reassignment capacity reached
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic cmd_done, // Completion pulse to host
	output logic [27:0] seek_target, // Requested track or LBA
	output logic [3:0] seek_head // Selected head
);
	dsf_state_type s;
	dsf_state_type next_s;

	function automatic logic xfer_ok(input logic [7:0] v);
		logic [2:0] m;
		m = v[2:0];
		unique case (v[7:3])
			DSF_T_PIO_DEF: xfer_ok = (m <= 3'h1);
			DSF_T_PIO_FC: xfer_ok = (m <= DSF_MAX_PIO);
			DSF_T_MWDMA: xfer_ok = (m <= DSF_MAX_MWDMA);
			DSF_T_UDMA: xfer_ok = (m <= DSF_MAX_UDMA);
			default: xfer_ok = 1'b0;
		endcase
	endfunction

	// Selector to link option bit; 05h and others are not defined
	function automatic logic [5:0] link_bit(input logic [7:0] v);
		unique case (v)
			8'h01: link_bit = 6'b100001;
			8'h02: link_bit = 6'b100010;
			8'h03: link_bit = 6'b100100;
			8'h04: link_bit = 6'b101000;
			8'h06: link_bit = 6'b110000;
			default: link_bit = 6'b000000;
		endcase
	endfunction

	logic wr_acc;
	logic rd_acc;
	logic [7:0] wb;
	logic mapped;
	logic [7:0] f;
	logic [7:0] sc;
	logic [5:0] lb;
	logic bad;
	logic [27:0] lba;

	always_comb
	begin
		wr_acc = psel && penable && pwrite && !s.pready;
		rd_acc = psel && penable && !pwrite && !s.pready;
		wb = pwdata[7:0];
		mapped = (paddr <= DSF_ADDR_CTRL) && (paddr[1:0] == 2'b00);
		f = s.tf.feature;
		sc = s.tf.seccnt;
		lb = link_bit(sc);
		bad = 1'b0;
		lba = {s.tf.head[3:0], s.tf.cylhi, s.tf.cyllo, s.tf.secnum};
		next_s = s;
		next_s.pready = psel && penable && !s.pready;
		next_s.pslverr = psel && penable && !s.pready && !mapped;
		next_s.done = 1'b0;
		if (rd_acc)
		begin
			next_s.prdata = 32'h0000_0000;
			unique case (paddr)
				DSF_ADDR_FEATURE: next_s.prdata[7:0] = s.error;
				DSF_ADDR_SECCNT: next_s.prdata[7:0] = s.tf.seccnt;
				DSF_ADDR_SECNUM: next_s.prdata[7:0] = s.tf.secnum;
				DSF_ADDR_CYLLO: next_s.prdata[7:0] = s.tf.cyllo;
				DSF_ADDR_CYLHI: next_s.prdata[7:0] = s.tf.cylhi;
				DSF_ADDR_HEAD: next_s.prdata[7:0] = s.tf.head;
				DSF_ADDR_CMD: next_s.prdata[7:0] = s.status;
				DSF_ADDR_OPTS: next_s.prdata = {11'h000, s.link_en, s.opts};
				DSF_ADDR_XFER: next_s.prdata[7:0] = s.xfer;
				DSF_ADDR_APM: next_s.prdata[7:0] = s.apm_level;
				DSF_ADDR_HTIME: next_s.prdata[7:0] = s.htime;
				DSF_ADDR_CTRL: next_s.prdata[0] = s.spinup;
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end
		// Task file writes are ignored while busy, as on a real drive
		if (wr_acc && !s.status[DSF_ST_BUSY])
		begin
			unique case (paddr)
				DSF_ADDR_FEATURE: next_s.tf.feature = wb;
				DSF_ADDR_SECCNT: next_s.tf.seccnt = wb;
				DSF_ADDR_SECNUM: next_s.tf.secnum = wb;
				DSF_ADDR_CYLLO: next_s.tf.cyllo = wb;
				DSF_ADDR_CYLHI: next_s.tf.cylhi = wb;
				DSF_ADDR_HEAD: next_s.tf.head = wb;
				DSF_ADDR_HTIME: next_s.htime = wb;
				DSF_ADDR_CTRL: next_s.spinup = s.spinup & ~wb[0];
				DSF_ADDR_CMD:
				begin
					next_s.tf.cmd = wb;
					next_s.error = 8'h00;
					next_s.status[DSF_ST_ERR] = 1'b0;
					if (wb[7:4] == DSF_CMD_SEEK_HI)
					begin
						next_s.phase = DSF_SEEK;
						next_s.status[DSF_ST_BUSY] = 1'b1;
						next_s.seek_cnt = DSF_SEEK_CYCLES;
						next_s.status[DSF_ST_SEEKDONE] = 1'b0;
					end
					else if (wb == DSF_CMD_SETF)
					begin
						next_s.phase = DSF_SETF;
						next_s.status[DSF_ST_BUSY] = 1'b1;
					end
					else
					begin
						next_s.phase = DSF_DONE;
						next_s.status[DSF_ST_BUSY] = 1'b1;
						next_s.error[DSF_ERR_ABORT] = 1'b1;
						next_s.status[DSF_ST_ERR] = 1'b1;
					end
				end
				default: next_s.tf = s.tf;
			endcase
		end
		if (realloc_full)
			next_s.opts[DSF_O_WC] = 1'b0;
		unique case (s.phase)
			DSF_IDLE: next_s.phase = next_s.phase;
			DSF_SEEK:
			begin
				// No format check: target is driven straight out
				next_s.target = s.tf.head[DSF_HEAD_LBA] ? lba
					: {12'h000, s.tf.cylhi, s.tf.cyllo};
				next_s.sel_head = s.tf.head[3:0];
				if (s.seek_cnt == 4'h1)
				begin
					next_s.phase = DSF_DONE;
					next_s.status[DSF_ST_SEEKDONE] = 1'b1;
					if (s.tf.head[DSF_HEAD_LBA])
					begin
						next_s.tf.secnum = s.target[7:0];
						next_s.tf.cyllo = s.target[15:8];
						next_s.tf.cylhi = s.target[23:16];
						next_s.tf.head[3:0] = s.target[27:24];
					end
				end
				next_s.seek_cnt = s.seek_cnt - 4'h1;
			end
			DSF_SETF:
			begin
				next_s.phase = DSF_DONE;
				unique case (f)
					DSF_F_WC_ON: next_s.opts[DSF_O_WC] = !realloc_full;
					DSF_F_WC_OFF: next_s.opts[DSF_O_WC] = 1'b0;
					DSF_F_RLA_OFF: next_s.opts[DSF_O_RLA] = 1'b0;
					DSF_F_RLA_ON: next_s.opts[DSF_O_RLA] = 1'b1;
					DSF_F_REV_OFF: next_s.opts[DSF_O_REV] = 1'b0;
					DSF_F_REV_ON: next_s.opts[DSF_O_REV] = 1'b1;
					DSF_F_APM_ON:
					begin
						if (sc == 8'h00 || sc == 8'hFF)
							bad = 1'b1;
						else
						begin
							next_s.opts[DSF_O_APM] = 1'b1;
							next_s.apm_level = sc;
						end
					end
					DSF_F_APM_OFF: next_s.opts[DSF_O_APM] = 1'b0;
					DSF_F_PUIS_ON: next_s.opts[DSF_O_PUIS] = 1'b1;
					DSF_F_PUIS_OFF: next_s.opts[DSF_O_PUIS] = 1'b0;
					DSF_F_SPINUP: next_s.spinup = 1'b1;
					DSF_F_OFS_ON: next_s.opts[DSF_O_OFS] = 1'b1;
					DSF_F_OFS_OFF: next_s.opts[DSF_O_OFS] = 1'b0;
					DSF_F_AAM_ON: next_s.opts[DSF_O_AAM] = 1'b1;
					DSF_F_AAM_OFF: next_s.opts[DSF_O_AAM] = 1'b0;
					DSF_F_HTIME: next_s.htime = sc;
					DSF_F_XFER:
					begin
						if (xfer_ok(sc))
							next_s.xfer = sc;
						else
							bad = 1'b1;
					end
					DSF_F_LINK_ON, DSF_F_LINK_OFF:
					begin
						if (!lb[5])
							bad = 1'b1;
						else if (f == DSF_F_LINK_ON)
							next_s.link_en = s.link_en | lb[4:0];
						else
							next_s.link_en = s.link_en & ~lb[4:0];
					end
					default: bad = 1'b1;
				endcase
				if (bad)
				begin
					next_s.error[DSF_ERR_ABORT] = 1'b1;
					next_s.status[DSF_ST_ERR] = 1'b1;
				end
			end
			DSF_DONE:
			begin
				next_s.phase = DSF_IDLE;
				next_s.status[DSF_ST_BUSY] = 1'b0;
				next_s.done = 1'b1;
			end
			default: next_s.phase = DSF_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.phase <= DSF_IDLE;
			s.opts <= DSF_OPTS_RESET;
			s.xfer <= DSF_XFER_RESET;
			s.status <= DSF_STATUS_RESET;
		end
		else
			s <= next_s;
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign cmd_done = s.done;
	assign seek_target = s.target;
	assign seek_head = s.sel_head;

	a_seek_busy: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && !s.status[DSF_ST_BUSY] && paddr == DSF_ADDR_CMD
		&& pwdata[7:4] == 4'h7 |=> s.phase == DSF_SEEK)
		else $error("seek not decoded");
	a_seek_ends: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s.phase == DSF_SEEK) |-> ##[4:5] s.phase == DSF_DONE)
		else $error("seek did not finish");
	a_lba_back: assert property (@(posedge pclk) disable iff (!presetn)
		s.phase == DSF_SEEK && s.seek_cnt == 4'h1 && s.tf.head[6]
		|=> s.tf.secnum == s.target[7:0]
		&& s.tf.head[3:0] == s.target[27:24])
		else $error("lba not returned");
	a_bad_feat: assert property (@(posedge pclk) disable iff (!presetn)
		s.phase == DSF_SETF && s.tf.feature == 8'h01
		|=> s.error[2] && s.status[0])
		else $error("undefined feature not aborted");
	a_wc_off: assert property (@(posedge pclk) disable iff (!presetn)
		realloc_full |=> !s.opts[0])
		else $error("write cache not forced off");
	a_wc_on: assert property (@(posedge pclk) disable iff (!presetn)
		s.phase == DSF_SETF && s.tf.feature == 8'h02 && !realloc_full
		|=> s.opts[0] && !s.error[2])
		else $error("write cache not enabled");
	a_rla_off: assert property (@(posedge pclk) disable iff (!presetn)
		s.phase == DSF_SETF && s.tf.feature == 8'h55 |=> !s.opts[1])
		else $error("look-ahead not disabled");
	a_xfer_set: assert property (@(posedge pclk) disable iff (!presetn)
		s.phase == DSF_SETF && s.tf.feature == 8'h03
		&& s.tf.seccnt == 8'h46 |=> s.xfer == 8'h46 ##1 s.done)
		else $error("mode not taken");
	a_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
		s.done |-> !s.status[7] && s.phase == DSF_IDLE)
		else $error("completion while busy");
endmodule

// ==== dsf_pkg.sv ====
// Package: register map, field layout and command decode constants
// Function
// - Any command byte 7xh is a seek; low nibble ignored.
// - Seek positions to requested track and head, even unformatted.
// - After an LBA seek the current LBA is loaded back.
// - Command EFh is set-features; feature code and sector count sub-value.
// - Undefined feature code sets abort flag and error status.
// - 02h enables write cache, 82h disables it.
// - 55h disables read look-ahead, AAh enables it.
// - 66h disables reverting to defaults, CCh enables it.
// - 05h enables power management with level, 85h disables.
// - 06h/86h enable/disable standby power-up, 07h requests spin-up.
// - 09h enables address offset mode, 89h disables it.
// - 42h enables acoustic management, C2h disables it.
// - 43h accepts a host maximum interface sector time.
// - 10h/90h enable/disable the link sub-feature chosen by sector count.
// - Sub-feature selectors 01h,02h,03h,04h,06h map to five link options.
// - Reset defaults: cache on, look-ahead on, reverting off, release off.
// - 03h splits sector count into 5-bit type and 3-bit mode.
// - Type 0 mode 0 default PIO; mode 1 PIO without ready.
// - Type 1 PIO 0-4, type 4 multiword DMA 0-2, type 8 UDMA 0-6.
// - When reassignment is full, cache stays off; 02h still accepted.
package dsf_pkg;
	localparam logic [11:0] DSF_ADDR_DATA = 12'h000;
	localparam logic [11:0] DSF_ADDR_FEATURE = 12'h004;
	localparam logic [11:0] DSF_ADDR_SECCNT = 12'h008;
	localparam logic [11:0] DSF_ADDR_SECNUM = 12'h00C;
	localparam logic [11:0] DSF_ADDR_CYLLO = 12'h010;
	localparam logic [11:0] DSF_ADDR_CYLHI = 12'h014;
	localparam logic [11:0] DSF_ADDR_HEAD = 12'h018;
	localparam logic [11:0] DSF_ADDR_CMD = 12'h01C;
	localparam logic [11:0] DSF_ADDR_OPTS = 12'h020;
	localparam logic [11:0] DSF_ADDR_XFER = 12'h024;
	localparam logic [11:0] DSF_ADDR_APM = 12'h028;
	localparam logic [11:0] DSF_ADDR_HTIME = 12'h02C;
	localparam logic [11:0] DSF_ADDR_CTRL = 12'h030;
	localparam logic [3:0] DSF_CMD_SEEK_HI = 4'h7;
	localparam logic [7:0] DSF_CMD_SETF = 8'hEF;
	localparam logic [7:0] DSF_F_WC_ON = 8'h02;
	localparam logic [7:0] DSF_F_XFER = 8'h03;
	localparam logic [7:0] DSF_F_APM_ON = 8'h05;
	localparam logic [7:0] DSF_F_PUIS_ON = 8'h06;
	localparam logic [7:0] DSF_F_SPINUP = 8'h07;
	localparam logic [7:0] DSF_F_OFS_ON = 8'h09;
	localparam logic [7:0] DSF_F_LINK_ON = 8'h10;
	localparam logic [7:0] DSF_F_AAM_ON = 8'h42;
	localparam logic [7:0] DSF_F_HTIME = 8'h43;
	localparam logic [7:0] DSF_F_RLA_OFF = 8'h55;
	localparam logic [7:0] DSF_F_REV_OFF = 8'h66;
	localparam logic [7:0] DSF_F_WC_OFF = 8'h82;
	localparam logic [7:0] DSF_F_APM_OFF = 8'h85;
	localparam logic [7:0] DSF_F_PUIS_OFF = 8'h86;
	localparam logic [7:0] DSF_F_OFS_OFF = 8'h89;
	localparam logic [7:0] DSF_F_LINK_OFF = 8'h90;
	localparam logic [7:0] DSF_F_RLA_ON = 8'hAA;
	localparam logic [7:0] DSF_F_AAM_OFF = 8'hC2;
	localparam logic [7:0] DSF_F_REV_ON = 8'hCC;
	localparam logic [4:0] DSF_T_PIO_DEF = 5'h00;
	localparam logic [4:0] DSF_T_PIO_FC = 5'h01;
	localparam logic [4:0] DSF_T_MWDMA = 5'h04;
	localparam logic [4:0] DSF_T_UDMA = 5'h08;
	localparam logic [2:0] DSF_MAX_PIO = 3'h4;
	localparam logic [2:0] DSF_MAX_MWDMA = 3'h2;
	localparam logic [2:0] DSF_MAX_UDMA = 3'h6;
	localparam int DSF_ERR_ABORT = 2;
	localparam int DSF_ERR_IDNF = 4;
	localparam int DSF_ST_ERR = 0;
	localparam int DSF_ST_SEEKDONE = 4;
	localparam int DSF_ST_READY = 6;
	localparam int DSF_ST_BUSY = 7;
	localparam int DSF_HEAD_LBA = 6;
	localparam logic [7:0] DSF_XFER_RESET = 8'h00;
	// Ready and seek complete set, busy and error clear
	localparam logic [7:0] DSF_STATUS_RESET = 8'h50;
	// Option bits in the options register
	localparam int DSF_O_WC = 0;
	localparam int DSF_O_RLA = 1;
	localparam int DSF_O_REV = 2;
	localparam int DSF_O_REL = 3;
	localparam int DSF_O_APM = 4;
	localparam int DSF_O_PUIS = 5;
	localparam int DSF_O_OFS = 6;
	localparam int DSF_O_AAM = 7;
	localparam logic [15:0] DSF_OPTS_RESET = 16'h0003;
	localparam logic [3:0] DSF_SEEK_CYCLES = 4'h4;

	typedef enum logic [3:0] {
		DSF_IDLE = 4'b0001,
		DSF_SEEK = 4'b0010,
		DSF_SETF = 4'b0100,
		DSF_DONE = 4'b1000
	} dsf_phase_type;

	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] seccnt;
		logic [7:0] secnum;
		logic [7:0] cyllo;
		logic [7:0] cylhi;
		logic [7:0] head;
		logic [7:0] cmd;
	} dsf_taskfile_type;

	typedef struct packed {
		dsf_phase_type phase;
		dsf_taskfile_type tf;
		logic [7:0] error;
		logic [7:0] status;
		logic [15:0] opts;
		logic [4:0] link_en;
		logic [7:0] xfer;
		logic [7:0] apm_level;
		logic [7:0] htime;
		logic spinup;
		logic [3:0] seek_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic done;
		logic [27:0] target;
		logic [3:0] sel_head;
	} dsf_state_type;
endpackage

// ==== dsf_host.sv ====
// Host adapter model: APB master that drives the task file
`timescale 1ns/1ps
module dsf_host
	import dsf_pkg::*;
(
	input wire logic pclk, // Bus clock
	output logic psel, // Select
	output logic penable, // Enable
	output logic pwrite, // Direction
	output logic [11:0] paddr, // Byte address
	output logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr // Error
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'hFFF;
		pwdata = 32'h0;
	end

	// Request stays put until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep looking valid
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ==== dsf_decoder_tb_top.sv ====
// Testbench for the seek and set-features decoder
`timescale 1ns/1ps
module dsf_decoder_tb_top
	import dsf_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic realloc_full, cmd_done, rd_e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic [27:0] seek_target;
	logic [3:0] seek_head;
	int failures = 0;
	int n_tests = 0;
	// Entry: feature, sector count, abort, register checked, value
	logic [63:0] tbl [36] = '{
		64'h02_00_00_20_00000003, 64'h82_00_00_20_00000002,
		64'h02_00_00_20_00000003, 64'h55_00_00_20_00000001,
		64'hAA_00_00_20_00000003, 64'hCC_00_00_20_00000007,
		64'h66_00_00_20_00000003, 64'h05_80_00_20_00000013,
		64'h05_80_00_28_00000080, 64'h85_00_00_20_00000003,
		64'h06_00_00_20_00000023, 64'h86_00_00_20_00000003,
		64'h09_00_00_20_00000043, 64'h89_00_00_20_00000003,
		64'h42_C0_00_20_00000083, 64'hC2_00_00_20_00000003,
		64'h10_01_00_20_00010003, 64'h10_02_00_20_00030003,
		64'h10_03_00_20_00070003, 64'h10_04_00_20_000F0003,
		64'h10_06_00_20_001F0003, 64'h90_01_00_20_001E0003,
		64'h43_20_00_2C_00000020, 64'h07_00_00_30_00000001,
		64'h01_00_01_20_001E0003, 64'h10_05_01_20_001E0003,
		64'h05_00_01_20_001E0003, 64'h03_01_00_24_00000001,
		64'h03_00_00_24_00000000, 64'h03_0C_00_24_0000000C,
		64'h03_22_00_24_00000022, 64'h03_46_00_24_00000046,
		64'h03_0D_01_24_00000046, 64'h03_23_01_24_00000046,
		64'h03_47_01_24_00000046, 64'h03_10_01_24_00000046
	};

	dsf_decoder dsf_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.realloc_full(realloc_full), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_done(cmd_done), .seek_target(seek_target),
		.seek_head(seek_head));
	dsf_host dsf_host_i (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	task chk(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task close_out();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		dsf_host_i.xfer(1'b1, a, {24'h0, d}, rd_q, rd_e);
	endtask

	task rd(input logic [11:0] a);
		dsf_host_i.xfer(1'b0, a, 32'h0, rd_q, rd_e);
	endtask

	task cmd(input logic [7:0] c);
		wr(DSF_ADDR_CMD, c);
		do
			@(posedge pclk);
		while (cmd_done !== 1'b1);
	endtask

	task setf(input logic [7:0] f, input logic [7:0] sc, input logic ab);
		wr(DSF_ADDR_FEATURE, f);
		wr(DSF_ADDR_SECCNT, sc);
		cmd(DSF_CMD_SETF);
		rd(DSF_ADDR_CMD);
		chk({rd_q[7], rd_q[3], rd_q[0]}, {2'b0, ab});
		rd(DSF_ADDR_FEATURE);
		chk(rd_q[DSF_ERR_ABORT], ab);
	endtask

	initial
	begin
		pclk = 1'b0;
		forever
			#5 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		close_out();
	end

	initial
	begin
		presetn = 1'b0;
		realloc_full = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(DSF_ADDR_CMD);
		chk(rd_q, DSF_STATUS_RESET);
		rd(DSF_ADDR_OPTS);
		chk(rd_q, DSF_OPTS_RESET);
		rd(12'h03C);
		chk({rd_e, rd_q}, {1'b1, 32'h0});
		for (int i = 0; i < 36; i++)
		begin
			setf(tbl[i][63:56], tbl[i][55:48], tbl[i][40]);
			rd({4'h0, tbl[i][39:32]});
			chk(rd_q, tbl[i][31:0]);
		end
		// Spin-up request flag clears on a write of one
		wr(DSF_ADDR_CTRL, 8'h01);
		rd(DSF_ADDR_CTRL);
		chk(rd_q[0], 1'b0);
		for (int l = 0; l < 2; l++)
		begin
			wr(DSF_ADDR_SECNUM, 8'h78);
			wr(DSF_ADDR_CYLLO, 8'h56);
			wr(DSF_ADDR_CYLHI, 8'h34);
			wr(DSF_ADDR_HEAD, (l == 1) ? 8'hE2 : 8'hA2);
			cmd((l == 1) ? 8'h7A : 8'h75);
			chk(seek_target, (l == 1) ? 28'h2345678 : 28'h0003456);
			chk(seek_head, 4'h2);
			rd(DSF_ADDR_SECNUM);
			chk(rd_q, 32'h78);
			rd(DSF_ADDR_CYLLO);
			chk(rd_q, 32'h56);
			rd(DSF_ADDR_CYLHI);
			chk(rd_q, 32'h34);
			rd(DSF_ADDR_HEAD);
			chk(rd_q[3:0], 4'h2);
			rd(DSF_ADDR_CMD);
			chk({rd_q[7], rd_q[4], rd_q[3], rd_q[0]}, 4'b0100);
		end
		// Unknown command aborts with no data phase
		cmd(8'hEE);
		rd(DSF_ADDR_CMD);
		chk({rd_q[7], rd_q[3], rd_q[0]}, 3'b001);
		wr(DSF_ADDR_HTIME, 8'h5A);
		rd(DSF_ADDR_HTIME);
		chk(rd_q, 32'h5A);
		// Hard reset in mid-run must restore the option defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(DSF_ADDR_OPTS);
		chk(rd_q, DSF_OPTS_RESET);
		realloc_full <= 1'b1;
		setf(DSF_F_WC_ON, 8'h00, 1'b0);
		rd(DSF_ADDR_OPTS);
		chk(rd_q[DSF_O_WC], 1'b0);
		close_out();
	end
endmodule
